// [iops_regs.vh]
`ifndef IOPS_REGS_VH
`define IOPS_REGS_VH
// ==========================================================
// register map (wishbone byte addresses)
`define IOPS_ADR_CTRL      4'h0
`define IOPS_ADR_STATUS    4'h4
`define IOPS_ADR_LATCH     4'h8
`define IOPS_ADR_CAL       4'hC
// control register fields
`define IOPS_CTRL_PWRFAIL  0
`define IOPS_CTRL_TAKEEN   1
`define IOPS_CTRL_RST      32'h0000_0000
// ==========================================================
// decode constants
`define IOPS_HIGH_PAGE     8'hFF
`define IOPS_LATCH_RST     8'h00
`define IOPS_CAL_PORT      6'h3F
`define IOPS_TAKE_PORT     7'h5C
`define IOPS_CAL_TIME_SZ   8'h0E
`define IOPS_CAL_GP_SZ     8'h32
// ==========================================================
// timing
`define IOPS_CLK_HZ        10000000
`define IOPS_PWR_HOLD_MS   500
// 0.5 s hold-off at the 10 MHz bus clock, sized for the 24-bit counter
`define IOPS_PWR_HOLD_CYC  24'h4C_4B40
`define IOPS_START_LEN     4'h3
`define IOPS_TAKE_TMO      24'h00_2710
`endif

// [iops_shift.v]
`timescale 1ns/1ns
// ==========================================================
// fixed-length shift register that times the printer start pulse
module iops_shift (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // trigger and pulse
  input  wire       trig_i,
  output wire       pulse_o
);
  reg [2:0] sh_reg; // stage chain

  // shift a one in on trigger, zeros otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 3'h0;
    end else begin
      sh_reg <= {sh_reg[1:0], trig_i};
    end
  end

  // pulse while any stage is set
  assign pulse_o = |sh_reg;
endmodule

// [iops_port_select.v]
`timescale 1ns/1ns
`include "iops_regs.vh"
module iops_port_select (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // bus status and address
  input  wire [15:0] bus_adr_i,
  input  wire        psync_i,
  input  wire        pdbin_i,
  input  wire        mwrite_i,
  // processor strobes
  input  wire        store_strobe_n_i,
  input  wire        fetch_strobe_n_i,
  input  wire        port_cycle_request_n_i,
  input  wire        memory_cycle_request_n_i,
  // printer
  input  wire        printer_buffer_full_n_i,
  input  wire        printer_busy_i,
  // power monitor
  input  wire        ctrl_power_ok_i,
  // status outputs
  output reg         sout_o,
  output reg         sinp_o,
  output reg         smemr_o,
  // strobes and drivers
  output reg  [7:0]  dev_sel_n_o,
  output reg  [1:0]  reg_sel_o,
  output reg         wr_strobe_n_o,
  output reg         rd_strobe_n_o,
  output reg         dout_drv_en_o,
  output reg         din_drv_en_o,
  output reg         cal_sel_o,
  output reg  [5:0]  cal_adr_o,
  output reg         prdy_o,
  output reg         processor_takeover_o,
  output reg         printer_start_o,
  output reg         printer_port_busy_o,
  output reg         sys_reset_o
);
  // ========================================================
  // input registers
  reg [15:0] adr_reg;      // sampled address
  reg        sync_reg;     // sampled sync
  reg        pdbin_reg;    // sampled data-in timing
  reg        mwr_reg;      // sampled memory write
  reg        st_n_reg;     // sampled store strobe
  reg        fe_n_reg;     // sampled fetch strobe
  reg        io_n_reg;     // sampled port request
  reg        mr_n_reg;     // sampled memory request
  reg        pbf_n_reg;    // sampled buffer full
  reg        busy_reg;     // sampled printer busy
  reg        pwr_reg;      // sampled power ok

  // register every asynchronous input once
  always @(posedge clk_i) begin
    if (rst_i) begin
      adr_reg   <= 16'h0000;
      sync_reg  <= 1'b0;
      pdbin_reg <= 1'b0;
      mwr_reg   <= 1'b0;
      st_n_reg  <= 1'b1;
      fe_n_reg  <= 1'b1;
      io_n_reg  <= 1'b1;
      mr_n_reg  <= 1'b1;
      pbf_n_reg <= 1'b1;
      busy_reg  <= 1'b0;
      pwr_reg   <= 1'b0;
    end else begin
      adr_reg   <= bus_adr_i;
      sync_reg  <= psync_i;
      pdbin_reg <= pdbin_i;
      mwr_reg   <= mwrite_i;
      st_n_reg  <= store_strobe_n_i;
      fe_n_reg  <= fetch_strobe_n_i;
      io_n_reg  <= port_cycle_request_n_i;
      mr_n_reg  <= memory_cycle_request_n_i;
      pbf_n_reg <= printer_buffer_full_n_i;
      busy_reg  <= printer_busy_i;
      pwr_reg   <= ctrl_power_ok_i;
    end
  end

  // ========================================================
  // cpu status decode
  // status lines built from processor strobes
  always @(posedge clk_i) begin
    if (rst_i) begin
      sout_o  <= 1'b0;
      sinp_o  <= 1'b0;
      smemr_o <= 1'b0;
    end else begin
      sout_o  <= ~st_n_reg & ~io_n_reg;
      sinp_o  <= ~fe_n_reg & ~io_n_reg;
      smemr_o <= ~fe_n_reg & ~mr_n_reg;
    end
  end

  // ========================================================
  // address latches
  reg  [3:0] lo_latch_reg;  // bits 0-3
  reg  [3:0] hi_latch_reg;  // qualifier, bit4, partial 5-7
  reg  [6:0] full_adr_reg;  // bits 0-6 for chip selects
  wire       page_ok;       // upper byte all ones
  reg        sync_d_reg;    // sync delayed for edge
  wire       sync_fall;     // end of address phase

  assign page_ok   = (adr_reg[15:8] == `IOPS_HIGH_PAGE);
  assign sync_fall = sync_d_reg & ~sync_reg;

  // latch while sync is high; hold until the next sync pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_d_reg   <= 1'b0;
      lo_latch_reg <= 4'h0;
      hi_latch_reg <= 4'h0;
      full_adr_reg <= 7'h00;
    end else begin
      sync_d_reg <= sync_reg;
      if (sync_reg) begin
        lo_latch_reg <= adr_reg[3:0];
        // bit3 qualifier, bit2 = A4, bits1:0 = A5/A6 group, A7 low
        hi_latch_reg <= {page_ok, adr_reg[4],
                         adr_reg[7] ? 2'b11 : adr_reg[6:5]};
        full_adr_reg <= adr_reg[6:0];
      end
    end
  end

  // ========================================================
  // device decode
  wire       board_sel;     // decoded board select
  wire [2:0] port_num;      // latched port number
  wire       is_cal;        // calendar range
  wire       is_take;       // takeover register
  reg        ctrl_take_en;  // software takeover enable

  assign board_sel = hi_latch_reg[3] & (hi_latch_reg[1:0] != 2'b11);
  // port number: A2/A3 from low latch, A4 from upper latch
  assign port_num  = {hi_latch_reg[2], lo_latch_reg[3:2]};
  assign is_cal    = hi_latch_reg[3] & (full_adr_reg[5:0] == `IOPS_CAL_PORT)
                     & ~full_adr_reg[6];
  assign is_take   = hi_latch_reg[3] &
                     (full_adr_reg == `IOPS_TAKE_PORT);

  // one-hot port select and register select
  always @(posedge clk_i) begin
    if (rst_i) begin
      dev_sel_n_o <= 8'hFF;
      reg_sel_o   <= 2'b00;
      cal_sel_o   <= 1'b0;
      cal_adr_o   <= 6'h00;
    end else begin
      dev_sel_n_o <= 8'hFF;
      if (board_sel & ~is_cal) begin
        dev_sel_n_o <= ~(8'h01 << port_num);
      end
      reg_sel_o <= lo_latch_reg[1:0];
      cal_sel_o <= is_cal;
      cal_adr_o <= full_adr_reg[5:0];
    end
  end

  // ========================================================
  // read and write gates
  wire wr_qual;             // write qualification
  wire rd_qual;             // read qualification

  assign wr_qual = ~sync_reg & ~smemr_o & (board_sel | is_cal);
  assign rd_qual = ~sync_reg & smemr_o & pdbin_reg & (board_sel | is_cal);

  // shared strobes also serve the calendar chip
  always @(posedge clk_i) begin
    if (rst_i) begin
      dout_drv_en_o <= 1'b0;
      wr_strobe_n_o <= 1'b1;
      rd_strobe_n_o <= 1'b1;
      din_drv_en_o  <= 1'b0;
    end else begin
      dout_drv_en_o <= wr_qual;
      wr_strobe_n_o <= ~(wr_qual & mwr_reg);
      rd_strobe_n_o <= ~rd_qual;
      din_drv_en_o  <= rd_qual;
    end
  end

  // ========================================================
  // processor-ready wait for the calendar
  // prdy low (wait) during the first qualified calendar cycle
  reg cal_done_reg;         // one wait per access

  always @(posedge clk_i) begin
    if (rst_i) begin
      prdy_o       <= 1'b1;
      cal_done_reg <= 1'b0;
    end else begin
      if (sync_reg) begin
        cal_done_reg <= 1'b0;
        prdy_o       <= 1'b1;
      end else if (is_cal & ~cal_done_reg) begin
        prdy_o       <= 1'b0;
        cal_done_reg <= 1'b1;
      end else begin
        prdy_o <= 1'b1;
      end
    end
  end

  // calendar storage sizes shown in the calendar register
  wire [7:0] cal_time_sz = `IOPS_CAL_TIME_SZ;
  wire [7:0] cal_gp_sz   = `IOPS_CAL_GP_SZ;

  // ========================================================
  // takeover request flip-flop
  // held high while the host keeps addressing the takeover port
  reg [23:0] take_cnt_reg;  // hold time left after last takeover access

  always @(posedge clk_i) begin
    if (rst_i | sys_reset_o) begin
      take_cnt_reg         <= 24'h00_0000;
      processor_takeover_o <= 1'b0;
    end else if (is_take & sync_fall & ctrl_take_en) begin
      take_cnt_reg         <= `IOPS_TAKE_TMO;
      processor_takeover_o <= 1'b1;
    end else if (take_cnt_reg != 24'h00_0000) begin
      take_cnt_reg <= take_cnt_reg - 24'h00_0001;
    end else begin
      processor_takeover_o <= 1'b0;
    end
  end

  // ========================================================
  // printer start pulse and busy wait
  reg  pbf_d_reg;           // buffer-full history
  wire start_pulse;         // shift register output

  always @(posedge clk_i) begin
    if (rst_i) begin
      pbf_d_reg <= 1'b1;
    end else begin
      pbf_d_reg <= pbf_n_reg;
    end
  end

  iops_shift u_shift (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .trig_i  (pbf_d_reg & ~pbf_n_reg),
    .pulse_o (start_pulse)
  );

  // start pulse and busy output registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      printer_start_o     <= 1'b0;
      printer_port_busy_o <= 1'b0;
    end else begin
      printer_start_o     <= start_pulse;
      printer_port_busy_o <= busy_reg & ~pbf_n_reg;
    end
  end

  // ========================================================
  // power-fail reset
  parameter [23:0] PWR_HOLD = `IOPS_PWR_HOLD_CYC;
  reg [23:0] pwr_cnt_reg;   // hold-off counter
  reg        ctrl_pwrfail;  // software forced power fail

  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_cnt_reg <= PWR_HOLD;
      sys_reset_o <= 1'b1;
    end else if (~pwr_reg | ctrl_pwrfail) begin
      pwr_cnt_reg <= PWR_HOLD;
      sys_reset_o <= 1'b1;
    end else if (pwr_cnt_reg != 24'h00_0000) begin
      pwr_cnt_reg <= pwr_cnt_reg - 24'h00_0001;
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= 1'b0;
    end
  end

  // ========================================================
  // wishbone slave
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // one-wait-state ack, register write and read mux
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      ctrl_pwrfail <= 1'b0;
      ctrl_take_en <= 1'b1;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `IOPS_ADR_CTRL)) begin
        ctrl_pwrfail <= wb_dat_i[`IOPS_CTRL_PWRFAIL];
        ctrl_take_en <= wb_dat_i[`IOPS_CTRL_TAKEEN];
      end
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `IOPS_ADR_CTRL: begin
            wb_dat_o <= {30'h0000_0000, ctrl_take_en, ctrl_pwrfail};
          end
          `IOPS_ADR_STATUS: begin
            wb_dat_o <= {24'h00_0000, sys_reset_o, processor_takeover_o,
                         printer_port_busy_o, prdy_o, cal_sel_o,
                         board_sel, ~rd_strobe_n_o, ~wr_strobe_n_o};
          end
          `IOPS_ADR_LATCH: begin
            wb_dat_o <= {16'h0000, dev_sel_n_o, hi_latch_reg, lo_latch_reg};
          end
          `IOPS_ADR_CAL: begin
            wb_dat_o <= {16'h0000, cal_gp_sz, cal_time_sz};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule

// [iops_port_select_asserts.sv]
`timescale 1ns/1ns
// ==========================================================
// checker on the top ports of the port select logic
module iops_port_select_asserts #(
  parameter [23:0] PWR_HOLD = 24'h00_0014
) (
  // clock and reset
  input wire       clk_i, rst_i,
  // processor and printer inputs
  input wire       store_strobe_n_i, fetch_strobe_n_i, pdbin_i, mwrite_i,
  input wire       port_cycle_request_n_i, memory_cycle_request_n_i,
  input wire       printer_buffer_full_n_i, printer_busy_i, ctrl_power_ok_i,
  // outputs
  input wire       sout_o, sinp_o, smemr_o, wr_strobe_n_o, rd_strobe_n_o,
  input wire [7:0] dev_sel_n_o,
  input wire       cal_sel_o, prdy_o, printer_start_o, printer_port_busy_o, sys_reset_o
);
  reg [1:0]  ok_cnt;  // edges since reset release, saturating
  reg [23:0] pok_cnt; // edges with power good
  wire       ok = (ok_cnt == 2'h3);
  // helper counters
  always @(posedge clk_i) begin
    ok_cnt <= rst_i ? 2'h0 : (ok ? ok_cnt : ok_cnt + 2'h1);
    pok_cnt <= (rst_i || !ctrl_power_ok_i) ? 24'h00_0000 : pok_cnt + 24'h00_0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; ##[1:5] printer_start_o; endsequence
  property p_sout; ok |-> sout_o == (!$past(store_strobe_n_i, 2) && !$past(port_cycle_request_n_i, 2)); endproperty
  property p_sinp; ok |-> sinp_o == (!$past(fetch_strobe_n_i, 2) && !$past(port_cycle_request_n_i, 2)); endproperty
  property p_smemr; ok |-> smemr_o == (!$past(fetch_strobe_n_i, 2) && !$past(memory_cycle_request_n_i, 2)); endproperty
  property p_onehot; $countones(~dev_sel_n_o) <= 1; endproperty
  property p_rd; ok && !rd_strobe_n_o |-> $past(pdbin_i) || $past(pdbin_i, 2); endproperty
  property p_wr; ok && !wr_strobe_n_o |-> $past(mwrite_i) || $past(mwrite_i, 2); endproperty
  property p_start; ok && $fell(printer_buffer_full_n_i) |-> s_start; endproperty
  property p_busy; ok && $past(printer_busy_i) && !$past(printer_buffer_full_n_i) && $past(printer_busy_i, 2) && !$past(printer_buffer_full_n_i, 2) |-> printer_port_busy_o; endproperty
  property p_pwr; !ctrl_power_ok_i |-> ##[1:3] sys_reset_o; endproperty
  property p_hold; ok && $fell(sys_reset_o) |-> pok_cnt >= PWR_HOLD - 24'h00_0001; endproperty
  property p_prdy; ok && $rose(cal_sel_o) |-> ##[0:3] !prdy_o; endproperty
  a_sout: assert property (p_sout) else $error("sout mismatch");
  a_sinp: assert property (p_sinp) else $error("sinp mismatch");
  a_smemr: assert property (p_smemr) else $error("smemr mismatch");
  a_onehot: assert property (p_onehot) else $error("select not one-hot");
  a_rd: assert property (p_rd) else $error("read strobe without pdbin");
  a_wr: assert property (p_wr) else $error("write strobe without mwrite");
  a_start: assert property (p_start) else $error("no start pulse");
  a_busy: assert property (p_busy) else $error("port busy missing");
  a_pwr: assert property (p_pwr) else $error("no reset on power loss");
  a_hold: assert property (p_hold) else $error("reset released early");
  a_prdy: assert property (p_prdy) else $error("no ready wait");
endmodule
bind iops_port_select iops_port_select_asserts #(.PWR_HOLD(PWR_HOLD)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .store_strobe_n_i(store_strobe_n_i),
  .fetch_strobe_n_i(fetch_strobe_n_i), .pdbin_i(pdbin_i), .mwrite_i(mwrite_i),
  .port_cycle_request_n_i(port_cycle_request_n_i),
  .memory_cycle_request_n_i(memory_cycle_request_n_i),
  .printer_buffer_full_n_i(printer_buffer_full_n_i), .printer_busy_i(printer_busy_i),
  .ctrl_power_ok_i(ctrl_power_ok_i), .sout_o(sout_o), .sinp_o(sinp_o), .smemr_o(smemr_o),
  .wr_strobe_n_o(wr_strobe_n_o), .rd_strobe_n_o(rd_strobe_n_o), .dev_sel_n_o(dev_sel_n_o),
  .cal_sel_o(cal_sel_o), .prdy_o(prdy_o), .printer_start_o(printer_start_o),
  .printer_port_busy_o(printer_port_busy_o), .sys_reset_o(sys_reset_o));

// [iops_host_model.sv]
`timescale 1ns/1ns
// ==========================================================
// host processor board driving the bus side
module iops_host_model (
  input  wire         clk_i,                                // bus clock
  output logic [15:0] bus_adr_o,                            // address lines
  output logic        psync_o, pdbin_o, mwrite_o,           // bus status
  output logic        store_n_o, fetch_n_o, port_n_o, mem_n_o // processor strobes
);
  // all strobes inactive
  task automatic idle();
    {psync_o, pdbin_o, mwrite_o} <= 3'h0;
    {store_n_o, fetch_n_o, port_n_o, mem_n_o} <= 4'hF;
  endtask
  initial begin
    bus_adr_o <= 16'h0000;
    idle();
  end
  // one access: mode 0 write, 1 memory-status read, 2 port input read
  task automatic cycle(input logic [15:0] adr, input logic [1:0] mode);
    @(posedge clk_i);
    bus_adr_o <= adr;
    psync_o <= 1'b1;
    @(posedge clk_i);
    psync_o <= 1'b0;
    store_n_o <= (mode != 2'h0);
    fetch_n_o <= (mode == 2'h0);
    port_n_o <= (mode == 2'h1);
    mem_n_o <= (mode != 2'h1);
    repeat (2) @(posedge clk_i);
    mwrite_o <= (mode == 2'h0);
    pdbin_o <= (mode != 2'h0);
    repeat (4) @(posedge clk_i);
    idle();
    bus_adr_o <= ~adr; // released lines do not keep the address
  endtask
endmodule

// [iops_port_select_tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, a, b); end end
// ==========================================================
// self-checking bench
module iops_port_select_tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, pbf_n = 1, pbusy = 0, pwr_ok = 1, rq = 1, wq_s = 1, saw_start = 0;
  logic [15:0] adr;
  logic psync, pdbin, mwrite, st_n, fe_n, po_n, me_n;
  logic sout, sinp, smemr, wr_n, rd_n, din, dout, cal, prdy, take, start, pbo, sysr;
  logic [7:0] sel_n;
  logic [1:0] rsel;
  logic [5:0] cadr;
  logic [63:0] wbq[$];  // expected read data with mask
  logic [9:0] selq[$];  // expected register and port select
  logic [9:0] sel_exp;  // oldest select note, popped once
  int fail_count = 0, checked = 0, seed = 67228, n;
  logic [2:0] num;
  logic [1:0] rs;
  always #50 clk_i = ~clk_i;
  iops_host_model host_u (.clk_i(clk_i), .bus_adr_o(adr), .psync_o(psync), .pdbin_o(pdbin),
    .mwrite_o(mwrite), .store_n_o(st_n), .fetch_n_o(fe_n), .port_n_o(po_n), .mem_n_o(me_n));
  iops_port_select #(.PWR_HOLD(24'h00_0014)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_adr_i(adr), .psync_i(psync), .pdbin_i(pdbin), .mwrite_i(mwrite),
    .store_strobe_n_i(st_n), .fetch_strobe_n_i(fe_n), .port_cycle_request_n_i(po_n),
    .memory_cycle_request_n_i(me_n), .printer_buffer_full_n_i(pbf_n), .printer_busy_i(pbusy),
    .ctrl_power_ok_i(pwr_ok), .sout_o(sout), .sinp_o(sinp), .smemr_o(smemr),
    .dev_sel_n_o(sel_n), .reg_sel_o(rsel), .wr_strobe_n_o(wr_n), .rd_strobe_n_o(rd_n),
    .dout_drv_en_o(dout), .din_drv_en_o(din), .cal_sel_o(cal), .cal_adr_o(cadr), .prdy_o(prdy),
    .processor_takeover_o(take), .printer_start_o(start), .printer_port_busy_o(pbo),
    .sys_reset_o(sysr));
  // verdict and end of run
  task automatic close_out();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // classic wishbone single cycle; reads note the expected value
  task automatic wb_rw(input logic we, input logic [3:0] a, input logic [31:0] d, ed, m);
    if (!we) wbq.push_back({m, ed});
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  // count cycles until the power reset lets go
  task automatic rel_wait();
    n = 0;
    while (sysr !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
    `CHK(n >= 19 && n < 200, 1'b1)
  endtask
  // monitor: compares the oldest note when a result shows
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wbq.size() > 0) begin
      `CHK(wb_dat_o & wbq[0][63:32], wbq[0][31:0])
      void'(wbq.pop_front());
    end
    if (((rd_n === 1'b0 && rq) || (wr_n === 1'b0 && wq_s)) && selq.size() > 0) begin
      sel_exp = selq.pop_front();
      `CHK({rsel, sel_n}, sel_exp)
      `CHK(rd_n === 1'b0 ? din : dout, 1'b1)
    end
    rq <= rd_n;
    wq_s <= wr_n;
    if (start === 1'b1) saw_start <= 1'b1;
  end
  initial begin #3000000; fail_count++; close_out(); end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rel_wait();
    wb_rw(1'b0, 4'h2, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wb_rw(1'b0, 4'hC, 32'h0, 32'h0000_320E, 32'h0000_FFFF);
    wb_rw(1'b1, 4'h0, 32'h0000_0002, 32'h0, 32'h0);
    wb_rw(1'b0, 4'h0, 32'h0, 32'h0000_0002, 32'h0000_0003);
    for (int i = 0; i < 12; i++) begin
      {num, rs} = 5'($random(seed));
      selq.push_back({rs, ~(8'h01 << num)});
      host_u.cycle({11'h7F8, num, rs}, 2'(i % 2));
    end
    `CHK(selq.size(), 0)
    selq.push_back({2'h3, 8'hFF});
    fork host_u.cycle(16'hFF3F, 2'h1);
      begin
        repeat (5) @(posedge clk_i);
        `CHK(cal, 1'b1)
        `CHK(cadr, 6'h3F)
        `CHK(prdy, 1'b0)
      end
    join
    `CHK(take, 1'b0)
    repeat (3) host_u.cycle(16'hFF5C, 2'h2);
    `CHK(take, 1'b1)
    pbf_n <= 1'b0;
    pbusy <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(pbo, 1'b1)
    `CHK(saw_start, 1'b1)
    pwr_ok <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(sysr, 1'b1)
    `CHK(take, 1'b0)
    pwr_ok <= 1'b1;
    rel_wait();
    wb_rw(1'b1, 4'h0, 32'h0000_0003, 32'h0, 32'h0);
    `CHK(sysr, 1'b1)
    wb_rw(1'b1, 4'h0, 32'h0000_0002, 32'h0, 32'h0);
    rel_wait();
    close_out();
  end
endmodule
